// *** hdl/eit_pkg.sv ***
package eit_pkg;
    // Register byte addresses
    localparam logic [3:0] EIT_ADDR_MODE   = 4'h0;
    localparam logic [3:0] EIT_ADDR_PERIOD = 4'h4;
    localparam logic [3:0] EIT_ADDR_DUTY   = 4'h8;
    localparam logic [3:0] EIT_ADDR_STATUS = 4'hc;

    // Mode register fields
    localparam int EIT_BIT_RUN    = 7;
    localparam int EIT_BIT_CKS_HI = 6;
    localparam int EIT_BIT_CKS_LO = 4;
    localparam int EIT_BIT_MODE_HI = 3;
    localparam int EIT_BIT_MODE_LO = 2;
    localparam int EIT_BIT_IDLE   = 1;
    localparam int EIT_BIT_DRIVE  = 0;

    localparam logic [7:0] EIT_MODE_RESET = 8'h00;
    localparam logic [7:0] EIT_CMP_RESET  = 8'h00;
    localparam logic [7:0] EIT_CNT_CLEAR  = 8'h00;

    // Duty reload needs this many count clocks after a write
    localparam logic [1:0] EIT_RELOAD_CLOCKS = 2'h3;

    // Status register fields
    localparam int EIT_ST_OUT   = 0;
    localparam int EIT_ST_DUTY  = 1;
    localparam int EIT_ST_PEND  = 2;
    localparam int EIT_ST_CNT_LO = 8;

    localparam logic [1:0] EIT_RESP_OKAY   = 2'h0;
    localparam logic [1:0] EIT_RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        EIT_MODE_INTERVAL = 2'b00,
        EIT_MODE_CARRIER  = 2'b01,
        EIT_MODE_PWM      = 2'b10,
        EIT_MODE_BAD      = 2'b11
    } eit_mode_e;

    typedef enum logic [2:0] {
        EIT_CKS_DIV1    = 3'b000,
        EIT_CKS_DIV2    = 3'b001,
        EIT_CKS_DIV4    = 3'b010,
        EIT_CKS_DIV16   = 3'b011,
        EIT_CKS_DIV64   = 3'b100,
        EIT_CKS_DIV1024 = 3'b101
    } eit_cks_e;
endpackage : eit_pkg

// *** hdl/eit_prescaler.sv ***
`timescale 1ns/1ps
module eit_prescaler
    import eit_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       run,
    input  wire logic [2:0] sel,
    output logic            tick
);
    typedef struct packed {
        logic [9:0] div;
        logic       tick;
    } eit_pre_s;

    eit_pre_s st_r;
    eit_pre_s st_nxt;

    // Terminal-count check shared by every divide ratio except divide-by-1
    function automatic logic at_end(input logic [9:0] d, input logic [9:0] mask);
        at_end = (d & mask) == mask;
    endfunction : at_end

    always_comb begin
        st_nxt = st_r;
        st_nxt.div = run ? st_r.div + 10'h001 : 10'h000;
        case (eit_cks_e'(sel))
            EIT_CKS_DIV1:    st_nxt.tick = run;
            EIT_CKS_DIV2:    st_nxt.tick = run && at_end(st_r.div, 10'h001);
            EIT_CKS_DIV4:    st_nxt.tick = run && at_end(st_r.div, 10'h003);
            EIT_CKS_DIV16:   st_nxt.tick = run && at_end(st_r.div, 10'h00f);
            EIT_CKS_DIV64:   st_nxt.tick = run && at_end(st_r.div, 10'h03f);
            EIT_CKS_DIV1024: st_nxt.tick = run && at_end(st_r.div, 10'h3ff);
            // Prohibited codes give no count clock at all
            default:         st_nxt.tick = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tick = st_r.tick;
endmodule : eit_prescaler

// *** hdl/eit_timer.sv ***
// Added by the designer: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
// What this block does
// - Interval: period match raises interrupt, clears counter
// - Interval: duty register matches are ignored
// - Interval with drive: output toggles per match
// - Clear, toggle and interrupt share one tick
// - Stop in interval: outputs return to idle
// - Start counts; output idle until first match
// - PWM period match: clear, interrupt, toggle, switch
// - PWM duty match: toggle and switch only
// - PWM cycle N+1, active width M+1
// - Running duty writes wait in a latch
// - Reload needs three count clocks after write
// - Duty writes accepted any time while counting
// - Stop in PWM: outputs forced idle
// - Stopped counter holds zero
// - Clock select: 1,2,4,16,64,1024 dividers
// - Idle level bit picks low or high
module eit_timer
    import eit_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             timer_output_pin,
    output logic             compare_match_irq
);
    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        aw_held;
        logic        w_held;
        logic [3:0]  aw_addr;
        logic [7:0]  w_data;
        logic        w_lane;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic [7:0]  mode;
        logic [7:0]  period_compare;
        logic [7:0]  duty_compare;
        logic [7:0]  duty_latch;
        logic        duty_pend;
        logic [1:0]  pend_age;
        logic [7:0]  count;
        logic        use_duty;
        logic        out;
        logic        irq;
        logic        run_d;
    } eit_state_s;

    eit_state_s st_r;
    eit_state_s st_nxt;
    logic       tick;
    logic       run;
    eit_mode_e  mode;
    logic       drive;
    logic       idle;
    logic       per_hit;
    logic       duty_hit;

    assign run   = st_r.mode[EIT_BIT_RUN];
    assign mode  = eit_mode_e'(st_r.mode[EIT_BIT_MODE_HI:EIT_BIT_MODE_LO]);
    assign drive = st_r.mode[EIT_BIT_DRIVE];
    assign idle  = st_r.mode[EIT_BIT_IDLE];

    eit_prescaler u_pre (
        .core_clk (core_clk),
        .rst      (rst),
        .run      (run),
        .sel      (st_r.mode[EIT_BIT_CKS_HI:EIT_BIT_CKS_LO]),
        .tick     (tick)
    );

    // Only one compare is live at a time; interval mode never looks at duty
    assign per_hit  = run && tick && !st_r.use_duty && st_r.count == st_r.period_compare;
    assign duty_hit = run && tick && st_r.use_duty && mode == EIT_MODE_PWM
                      && st_r.count == st_r.duty_compare;

    always_comb begin
        logic wr_go;
        logic [7:0] wv;
        wr_go = 1'b0;
        wv = 8'h00;
        st_nxt = st_r;
        st_nxt.irq = 1'b0;
        st_nxt.run_d = run;

        // Write channel: address and data accepted in either order
        if (s_axi_awvalid && st_r.awready) begin
            st_nxt.aw_held = 1'b1;
            st_nxt.aw_addr = s_axi_awaddr;
            st_nxt.awready = 1'b0;
        end
        if (s_axi_wvalid && st_r.wready) begin
            st_nxt.w_held = 1'b1;
            st_nxt.w_data = s_axi_wdata[7:0];
            st_nxt.w_lane = s_axi_wstrb[0];
            st_nxt.wready = 1'b0;
        end
        if (st_r.aw_held && st_r.w_held && !st_r.bvalid) begin
            wr_go = st_r.w_lane;
            wv = st_r.w_data;
            st_nxt.aw_held = 1'b0;
            st_nxt.w_held = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = (st_r.aw_addr[3:2] == EIT_ADDR_STATUS[3:2]) ? EIT_RESP_SLVERR : EIT_RESP_OKAY;
        end
        if (st_r.bvalid && s_axi_bready) begin
            st_nxt.bvalid = 1'b0;
            st_nxt.awready = 1'b1;
            st_nxt.wready = 1'b1;
        end

        // Counter engine
        if (!run) begin
            st_nxt.count = EIT_CNT_CLEAR;
            st_nxt.use_duty = 1'b0;
            st_nxt.out = idle;
            st_nxt.duty_pend = 1'b0;
        end else begin
            if (!st_r.run_d) begin
                st_nxt.out = idle;
            end
            if (tick && st_r.duty_pend && st_r.pend_age != EIT_RELOAD_CLOCKS) begin
                st_nxt.pend_age = st_r.pend_age + 2'h1;
            end
            if (per_hit) begin
                st_nxt.count = EIT_CNT_CLEAR;
                st_nxt.irq = 1'b1;
                if (drive) begin
                    st_nxt.out = !st_r.out;
                end
                st_nxt.use_duty = (mode == EIT_MODE_PWM);
            end else if (duty_hit) begin
                st_nxt.count = st_r.count + 8'h01;
                if (drive) begin
                    st_nxt.out = !st_r.out;
                end
                st_nxt.use_duty = 1'b0;
                // A write landing inside the last three count clocks misses this match
                if (st_r.duty_pend && st_r.pend_age == EIT_RELOAD_CLOCKS) begin
                    st_nxt.duty_compare = st_r.duty_latch;
                    st_nxt.duty_pend = 1'b0;
                end
            end else if (tick) begin
                st_nxt.count = st_r.count + 8'h01;
            end
        end

        if (wr_go) begin
            case (st_r.aw_addr[3:2])
                EIT_ADDR_MODE[3:2]:   st_nxt.mode = wv;
                EIT_ADDR_PERIOD[3:2]: st_nxt.period_compare = wv;
                EIT_ADDR_DUTY[3:2]: begin
                    if (run) begin
                        st_nxt.duty_latch = wv;
                        st_nxt.duty_pend = 1'b1;
                        st_nxt.pend_age = 2'h0;
                        // A write that meets a reload cancels that transfer
                        st_nxt.duty_compare = st_r.duty_compare;
                    end else begin
                        st_nxt.duty_compare = wv;
                        st_nxt.duty_latch = wv;
                    end
                end
                default: ;
            endcase
        end

        // Read channel
        if (s_axi_arvalid && st_r.arready) begin
            st_nxt.arready = 1'b0;
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp = EIT_RESP_OKAY;
            case (s_axi_araddr[3:2])
                EIT_ADDR_MODE[3:2]:   st_nxt.rdata = {24'h000000, st_r.mode};
                EIT_ADDR_PERIOD[3:2]: st_nxt.rdata = {24'h000000, st_r.period_compare};
                EIT_ADDR_DUTY[3:2]:   st_nxt.rdata = {24'h000000, st_r.duty_compare};
                default: begin
                    st_nxt.rdata = 32'h00000000;
                    st_nxt.rdata[EIT_ST_OUT] = st_r.out;
                    st_nxt.rdata[EIT_ST_DUTY] = st_r.use_duty;
                    st_nxt.rdata[EIT_ST_PEND] = st_r.duty_pend;
                    st_nxt.rdata[EIT_ST_CNT_LO +: 8] = st_r.count;
                end
            endcase
        end
        if (st_r.rvalid && s_axi_rready) begin
            st_nxt.rvalid = 1'b0;
            st_nxt.arready = 1'b1;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_r <= '0;
            st_r.awready <= 1'b1;
            st_r.wready <= 1'b1;
            st_r.arready <= 1'b1;
            st_r.mode <= EIT_MODE_RESET;
            st_r.period_compare <= EIT_CMP_RESET;
            st_r.duty_compare <= EIT_CMP_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign s_axi_awready     = st_r.awready;
    assign s_axi_wready      = st_r.wready;
    assign s_axi_bvalid      = st_r.bvalid;
    assign s_axi_bresp       = st_r.bresp;
    assign s_axi_arready     = st_r.arready;
    assign s_axi_rvalid      = st_r.rvalid;
    assign s_axi_rdata       = st_r.rdata;
    assign s_axi_rresp       = st_r.rresp;
    assign timer_output_pin  = st_r.out;
    assign compare_match_irq = st_r.irq;

    chk_period_clears: assert property (@(posedge core_clk) disable iff (rst)
        per_hit |=> st_r.count == 8'h00 && compare_match_irq)
        else $error("period match did not clear and interrupt");
    chk_interval_no_duty: assert property (@(posedge core_clk) disable iff (rst)
        mode == EIT_MODE_INTERVAL |-> !duty_hit && !st_r.use_duty)
        else $error("duty match seen in interval mode");
    chk_period_toggle: assert property (@(posedge core_clk) disable iff (rst)
        per_hit && drive |=> timer_output_pin != $past(timer_output_pin))
        else $error("output did not toggle on period match");
    chk_irq_cause: assert property (@(posedge core_clk) disable iff (rst)
        compare_match_irq |-> $past(per_hit))
        else $error("interrupt without period match");
    chk_stop_idle: assert property (@(posedge core_clk) disable iff (rst)
        !run ##1 !run && $stable(idle) |-> timer_output_pin == idle && !compare_match_irq)
        else $error("stopped timer not idle");
    chk_duty_quiet: assert property (@(posedge core_clk) disable iff (rst)
        duty_hit |=> !compare_match_irq && st_r.count != 8'h00)
        else $error("duty match cleared or interrupted");
    chk_stopped_zero: assert property (@(posedge core_clk) disable iff (rst)
        !run |=> st_r.count == 8'h00 && !st_r.use_duty)
        else $error("stopped counter not held at zero");
    chk_pwm_switch: assert property (@(posedge core_clk) disable iff (rst)
        per_hit && mode == EIT_MODE_PWM |=> st_r.use_duty)
        else $error("PWM did not switch to duty compare");
    chk_reload_wait: assert property (@(posedge core_clk) disable iff (rst)
        duty_hit && st_r.duty_pend && st_r.pend_age != EIT_RELOAD_CLOCKS |=> $stable(st_r.duty_compare))
        else $error("duty reloaded too early");

    // A start or a stop spans two samples of the run bit
    sequence seq_start;
        !run ##1 run;
    endsequence : seq_start
    sequence seq_stop;
        run ##1 !run;
    endsequence : seq_stop

    chk_start_idle: assert property (@(posedge core_clk) disable iff (rst)
        seq_start |=> timer_output_pin == $past(idle))
        else $error("output left idle level at start");
    chk_start_period: assert property (@(posedge core_clk) disable iff (rst)
        seq_start |-> !st_r.use_duty)
        else $error("run did not start on period compare");
    chk_stop_forced: assert property (@(posedge core_clk) disable iff (rst)
        seq_stop |=> timer_output_pin == $past(idle) && !compare_match_irq)
        else $error("stop did not force idle outputs");
    chk_duty_toggle: assert property (@(posedge core_clk) disable iff (rst)
        duty_hit && drive |=> timer_output_pin != $past(timer_output_pin) && !st_r.use_duty)
        else $error("duty match did not toggle and switch");
    chk_duty_hold: assert property (@(posedge core_clk) disable iff (rst)
        run && !duty_hit |=> $stable(st_r.duty_compare))
        else $error("duty compare changed outside a duty match");
    chk_bad_clock: assert property (@(posedge core_clk) disable iff (rst)
        st_r.mode[EIT_BIT_CKS_HI:EIT_BIT_CKS_LO] > EIT_CKS_DIV1024 |=> !tick)
        else $error("prohibited clock code produced a tick");
    chk_count_step: assert property (@(posedge core_clk) disable iff (rst)
        run && tick && !per_hit |=> st_r.count == $past(st_r.count) + 8'h01)
        else $error("counter did not advance on count clock");
    chk_count_hold: assert property (@(posedge core_clk) disable iff (rst)
        run && !tick |=> $stable(st_r.count))
        else $error("counter moved without count clock");
endmodule : eit_timer

// *** tb/eit_load.sv ***
`timescale 1ns/1ps
// Passive load on the timer pin: flags each level change and how long the old level lasted
module eit_load (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        timer_output_pin,
    output logic             edge_seen,
    output logic [15:0]      width
);
    logic prev_r;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            prev_r <= 1'b0;
            width  <= 16'h0000;
        end else begin
            prev_r <= timer_output_pin;
            width  <= (timer_output_pin != prev_r) ? 16'h0001 : width + 16'h0001;
        end
    end

    assign edge_seen = (timer_output_pin !== prev_r);
endmodule : eit_load

// *** tb/eit_timer_tb.sv ***
`timescale 1ns/1ps
module eit_timer_tb;
    import eit_pkg::*;
    logic        core_clk, rst;
    logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        timer_output_pin, compare_match_irq, edge_seen;
    logic [15:0] width;
    logic [1:0]  bq[$];
    logic [31:0] rq[$];
    logic [31:0] mq[$];
    logic        mon_on, seen_irq, seen_pin, idle;
    int          failures, n_checks, tmo, gap, n_irq, exp_gap, exp_act, exp_inact, n, m, k, seed_v;
    int          div_of[6] = '{1, 2, 4, 16, 64, 1024};

    eit_timer u_eit_timer (.core_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .timer_output_pin, .compare_match_irq);
    eit_load u_eit_load (.core_clk, .rst, .timer_output_pin, .edge_seen, .width);

    always #20 core_clk = ~core_clk;

    task automatic print_verdict();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : print_verdict

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] er);
        @(posedge core_clk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= {24'h000000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        bq.push_back(er);
        do begin
            @(posedge core_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] mk);
        @(posedge core_clk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        rq.push_back(e);
        mq.push_back(mk);
        do begin
            @(posedge core_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
    endtask : rd

    task automatic set_mode(input logic run, input logic [2:0] cks, input logic [1:0] md);
        wr(EIT_ADDR_MODE, {run, cks, md, idle, 1'b1}, EIT_RESP_OKAY);
    endtask : set_mode

    task automatic run_phase(input int cycles);
        mon_on <= 1'b1;
        repeat (cycles) @(posedge core_clk);
        mon_on <= 1'b0;
    endtask : run_phase

    task automatic stop_chk(input logic [2:0] cks, input logic [1:0] md);
        set_mode(1'b0, cks, md);
        repeat (2) @(posedge core_clk);
        check("stop_pin", timer_output_pin, idle);
        check("stop_irq", compare_match_irq, 1'b0);
        rd(EIT_ADDR_STATUS, {31'h0, idle}, 32'h0000ff07);
    endtask : stop_chk

    // Bus answers are matched in issue order; one of each kind is ever outstanding
    always @(posedge core_clk) begin
        if (s_axi_bvalid === 1'b1 && s_axi_bready) check("bresp", {30'h0, s_axi_bresp}, {30'h0, bq.pop_front()});
        if (s_axi_rvalid === 1'b1 && s_axi_rready) check("rdata", s_axi_rdata & mq.pop_front(), rq.pop_front());
        if (s_axi_rvalid === 1'b1 && s_axi_rready) check("rresp", {30'h0, s_axi_rresp}, {30'h0, EIT_RESP_OKAY});
    end

    // Sampled on the falling edge so design updates have landed; first event after arming only syncs
    always @(negedge core_clk) begin
        tmo++;
        gap++;
        if (!mon_on) begin
            seen_irq = 1'b0;
            seen_pin = 1'b0;
        end
        if (compare_match_irq === 1'b1) begin
            n_irq++;
            if (seen_irq) check("irq_gap", gap, exp_gap);
            seen_irq = 1'b1;
            gap = 0;
        end
        if (edge_seen) begin
            if (seen_pin) check("pin_width", width, (timer_output_pin === idle) ? exp_act : exp_inact);
            seen_pin = 1'b1;
        end
        if (tmo == 30000) begin
            failures++;
            print_verdict();
        end
    end

    initial begin
        core_clk = 1'b0;
        rst = 1'b1;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'h1;
        mon_on = 1'b0;
        idle = 1'b0;
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        seed_v = $urandom(32'h8bf0);
        rd(EIT_ADDR_MODE, {24'h0, EIT_MODE_RESET}, 32'hffffffff);
        rd(EIT_ADDR_PERIOD, {24'h0, EIT_CMP_RESET}, 32'hffffffff);
        rd(EIT_ADDR_DUTY, {24'h0, EIT_CMP_RESET}, 32'hffffffff);
        wr(EIT_ADDR_STATUS, 8'h5a, EIT_RESP_SLVERR);
        for (int c = 0; c < 6; c++) begin
            n = (c == 0) ? 3 + $urandom % 6 : 1;
            idle = c[0];
            exp_gap = (n + 1) * div_of[c];
            exp_act = exp_gap;
            exp_inact = exp_gap;
            wr(EIT_ADDR_PERIOD, n[7:0], EIT_RESP_OKAY);
            wr(EIT_ADDR_DUTY, 8'h00, EIT_RESP_OKAY);
            set_mode(1'b0, c[2:0], EIT_MODE_INTERVAL);
            set_mode(1'b1, c[2:0], EIT_MODE_INTERVAL);
            check("start_pin", timer_output_pin, idle);
            run_phase(exp_gap * 4 + 8);
            stop_chk(c[2:0], EIT_MODE_INTERVAL);
        end
        wr(EIT_ADDR_PERIOD, 8'h01, EIT_RESP_OKAY);
        set_mode(1'b1, 3'b110, EIT_MODE_INTERVAL);
        k = n_irq;
        repeat (50) @(posedge core_clk);
        check("bad_clock_irqs", n_irq, k);
        stop_chk(3'b110, EIT_MODE_INTERVAL);
        // Each pass restarts from stop, so the first match must again be the period one
        for (int r = 0; r < 2; r++) begin
            n = 4 + $urandom % 8;
            m = $urandom % n;
            idle = ~r[0];
            set_mode(1'b0, EIT_CKS_DIV1, EIT_MODE_PWM);
            wr(EIT_ADDR_PERIOD, n[7:0], EIT_RESP_OKAY);
            wr(EIT_ADDR_DUTY, m[7:0], EIT_RESP_OKAY);
            exp_gap = n + 1;
            exp_act = m + 1;
            exp_inact = n - m;
            set_mode(1'b1, EIT_CKS_DIV1, EIT_MODE_PWM);
            check("start_pin", timer_output_pin, idle);
            run_phase((n + 1) * 4);
            m = $urandom % n;
            wr(EIT_ADDR_DUTY, m[7:0], EIT_RESP_OKAY);
            repeat (3 * (n + 1)) @(posedge core_clk);
            exp_act = m + 1;
            exp_inact = n - m;
            run_phase((n + 1) * 4);
            stop_chk(EIT_CKS_DIV1, EIT_MODE_PWM);
        end
        print_verdict();
    end
endmodule : eit_timer_tb
